// File: bench/fmc_host.sv
// Behavioural SMBus host that masters the serial bus of the block.
`timescale 1ns/10ps
`include "fmc_cfg.svh"
module fmc_host (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      pull
);
  logic sda;
  // The wire has a pull-up, so a released line reads high.
  assign sda = !(sda_oe | pull);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data moves only while the clock is low and is held two cycles past the fall.
  task automatic bt(input logic b, output logic r);
    pull = !b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda;
    scl = 1'b0;
    tick(2);
  endtask
  task automatic start();
    pull = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    pull = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    pull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    pull = 1'b0;
    tick(4);
  endtask
  task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(m, r);
    a = !r;
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] p, input logic [7:0] d,
                    output logic a);
    logic [7:0] q;
    logic       a1;
    logic       a2;
    start();
    xb({ad, 1'b0}, 1'b1, q, a);
    xb(p, 1'b1, q, a1);
    xb(d, 1'b1, q, a2);
    stop();
    a = a & a1 & a2;
  endtask
  // Pointer write, repeated start, then one byte read closed by a no acknowledge.
  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    logic [7:0] x;
    logic       a;
    start();
    xb({`FMC_SLAVE_ADDR, 1'b0}, 1'b1, x, a);
    xb(p, 1'b1, x, a);
    start();
    xb({`FMC_SLAVE_ADDR, 1'b1}, 1'b1, x, a);
    xb(8'hff, 1'b1, q, a);
    stop();
  endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the fan monitor configuration and fail-safe block.
`timescale 1ns/10ps
`include "fmc_cfg.svh"
`define CHK(x, y) begin total_checks++; if ((x) !== (y)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, x, y); end end
module testbench;
  logic       clk;
  logic       srst;
  logic       msg;
  logic       cvg;
  logic [7:0] tmp;
  logic [7:0] ad;
  logic       alr;
  logic       scl;
  logic       pull;
  logic       sda_oe;
  logic       mf_oe;
  logic [2:0] fan;
  logic       mon;
  logic       rsig;
  logic       fs;
  logic       a;
  logic       ce;
  logic       mfi;
  int         n;
  int         n_fail;
  int         total_checks;
  always #5 clk = ~clk;
  fmc_host i_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .pull(pull));
  // Short counts keep the run brief; expectations below follow these values.
  fmc_top #(.HF_PERIOD_CYCLES(64), .LF_BASE_CYCLES(100), .HOST_TIMEOUT_CYCLES(200)) i_dut (
    .CLOCK(clk), .SRST(srst), .CE(ce), .SCL(scl), .SDA_IN(!(sda_oe | pull)),
    .SDA_OUT(), .SDA_OE(sda_oe), .MAIN_SUPPLY_GOOD(msg), .CORE_VOLTAGE_INPUT_GOOD(cvg),
    .TEMP_LOCAL(tmp), .TEMP_REMOTE1(tmp), .TEMP_REMOTE2(tmp), .AUTO_DUTY_1(ad),
    .AUTO_DUTY_2(ad), .AUTO_DUTY_3(ad), .FAN4_SPEED_ALARM(1'b0), .ALERT_REQUEST(alr),
    .MF_PIN_IN(mfi), .MF_PIN_OUT(), .MF_PIN_OE(mf_oe), .FAN_DRIVE(fan),
    .MONITOR_ENABLE(mon), .TEMP_RANGE_SIGNED(rsig), .FAIL_SAFE_ACTIVE(fs));
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic w(input logic [7:0] p, input logic [7:0] d);
    i_host.wr(`FMC_SLAVE_ADDR, p, d, a);
    `CHK(a, 1'b1)
  endtask
  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    i_host.rd(p, q);
    `CHK(q, e)
  endtask
  // Cycles between two rising edges of the first fan output.
  task automatic per(output int k);
    longint t;
    @(posedge fan[0]);
    t = $time;
    @(posedge fan[0]);
    k = int'(($time - t) / 10);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    ce = 1'b1;
    mfi = 1'b1;
    msg = 1'b0;
    cvg = 1'b0;
    tmp = 8'h10;
    ad = 8'h00;
    alr = 1'b0;
    n_fail = 0;
    total_checks = 0;
    step(4);
    srst = 1'b0;
    `CHK(fan, 3'h0)
    `CHK(rsig, 1'b1)
    msg = 1'b1;
    step(250);
    `CHK(fs, 1'b0)
    i_host.wr(7'h2f, 8'h30, 8'hff, a);
    `CHK(a, 1'b0)
    `CHK(mon, 1'b0)
    rchk(8'h7c, 8'h01);
    `CHK(mon, 1'b1)
    rchk(8'h7d, 8'h00);
    w(8'h30, 8'h80);
    per(n);
    `CHK(n, 64)
    w(8'h7c, 8'h03);
    per(n);
    `CHK(n, 100)
    w(`FMC_REG_LF_DIV, 8'h02);
    per(n);
    `CHK(n, 200)
    // A full automatic request against a zero cap shows the cap, not the request.
    ad = 8'hff;
    w(`FMC_REG_MAX_DUTY, 8'h00);
    w(`FMC_REG_AUTO_EN, 8'h07);
    `CHK(fan, 3'h0)
    w(`FMC_REG_MAX_DUTY, 8'hff);
    `CHK(fan, 3'h7)
    w(8'h7c, 8'h02);
    `CHK(rsig, 1'b0)
    alr = 1'b1;
    w(8'h7d, 8'h02);
    `CHK(mf_oe, 1'b1)
    w(8'h7d, 8'h00);
    `CHK(mf_oe, 1'b0)
    w(8'h7c, 8'h05);
    w(`FMC_REG_THERMAL_LIMIT_PIN_LIMIT, 8'h64);
    w(`FMC_REG_GPIO_DRIVE, 8'h01);
    w(8'h7d, 8'h03);
    `CHK(mf_oe, 1'b1)
    w(8'h7c, 8'h0d);
    `CHK(mf_oe, 1'b0)
    rchk(`FMC_REG_STATUS2, 8'h20);
    w(8'h7d, 8'h01);
    mfi = 1'b0;
    step(2);
    mfi = 1'b1;
    rchk(`FMC_REG_STATUS2, 8'h20);
    rchk(`FMC_REG_STATUS2, 8'h00);
    tmp = 8'h64;
    step(3);
    `CHK(fs, 1'b0)
    tmp = 8'h65;
    step(3);
    `CHK(fs, 1'b1)
    `CHK(fan, 3'h7)
    `CHK(mf_oe, 1'b1)
    tmp = 8'h10;
    step(3);
    `CHK(fs, 1'b0)
    // Second power-up with the core supply good from the start.
    srst = 1'b1;
    cvg = 1'b1;
    step(2);
    srst = 1'b0;
    step(2);
    `CHK(mon, 1'b1)
    step(150);
    `CHK(fs, 1'b0)
    // A frozen clock enable holds the host timer, so the timeout moves out.
    ce = 1'b0;
    step(100);
    `CHK(fs, 1'b0)
    ce = 1'b1;
    step(100);
    `CHK(fs, 1'b1)
    `CHK(fan, 3'h7)
    w(8'h30, 8'h00);
    `CHK(fs, 1'b0)
    `CHK(fan, 3'h0)
    step(300);
    `CHK(fs, 1'b0)
    tally_and_finish();
  end
endmodule

// File: hdl/fmc_cfg.svh
// Constants for the fan monitor configuration and fail-safe block.
`ifndef FMC_CFG_SVH
`define FMC_CFG_SVH
`define FMC_SLAVE_ADDR        7'h2e
`define FMC_REG_TEMP_LOCAL    8'h25
`define FMC_REG_TEMP_REMOTE1  8'h26
`define FMC_REG_TEMP_REMOTE2  8'h27
`define FMC_REG_DUTY1         8'h30
`define FMC_REG_DUTY2         8'h31
`define FMC_REG_DUTY3         8'h32
`define FMC_REG_MAX_DUTY      8'h38
`define FMC_REG_STATUS2       8'h42
`define FMC_REG_AUTO_EN       8'h5c
`define FMC_REG_LF_DIV        8'h5f
`define FMC_REG_THERMAL_LIMIT_PIN_LIMIT   8'h6a
`define FMC_REG_TEMP_OFFSET   8'h70
`define FMC_REG_CFG5          8'h7c
`define FMC_REG_CFG4          8'h7d
`define FMC_REG_GPIO_DRIVE    8'h7e
`define FMC_REG_SUPERVISOR    8'h7f
`define FMC_CFG5_RANGE        0
`define FMC_CFG5_LOWFREQ      1
`define FMC_CFG5_GPIO_DIR     2
`define FMC_CFG5_GPIO_POL     3
`define FMC_STATUS2_PIN       5
`define FMC_CFG5_RESET        8'h01
`define FMC_CFG4_RESET        8'h00
`define FMC_DUTY_RESET        8'h00
`define FMC_MAX_DUTY_RESET    8'hff
`define FMC_THERMAL_LIMIT_PIN_LIMIT_RESET 8'h64
`define FMC_OFFSET_RESET      8'h00
`define FMC_LF_DIV_RESET      4'h1
`define FMC_LF_DIV_MIN        4'h1
`define FMC_LF_DIV_MAX        4'ha
`define FMC_FULL_DUTY         8'hff
`define FMC_EXT_OFFSET        11'sh040
`define FMC_ROLE_FAN4         2'h0
`define FMC_ROLE_THERMAL_PIN  2'h1
`define FMC_ROLE_ALERT        2'h2
`define FMC_ROLE_GPIO         2'h3
`define FMC_BITS_PER_BYTE     4'h8
`define FMC_CLOCK_HZ          100000000
`define FMC_MS_PER_S          1000
`define FMC_HF_FREQ_HZ        22500
`define FMC_LF_MAX_FREQ_HZ    100
`define FMC_LF_MIN_FREQ_HZ    10
`define FMC_HOST_TIMEOUT_MS   4600
`endif

// File: hdl/fmc_drive.sv
// Fan drive generator: one pulse-width output with programmable period.
`timescale 1ns/10ps
`include "fmc_cfg.svh"
module fmc_drive (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [23:0] period,
  input  wire logic [7:0]  duty,
  input  wire logic        force_full,
  output logic             drive
);
  logic [23:0] cnt;
  logic [31:0] thr_prod;
  logic [23:0] thr;

  assign thr_prod = duty * period;
  assign thr      = thr_prod[31:8];

  // A period shrinking under a running count wraps at once instead of overrunning.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= '0;
    end else if (ce) begin
      if (cnt >= period - 24'h000001) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      drive <= 1'b0;
    end else if (ce) begin
      drive <= force_full || (duty == `FMC_FULL_DUTY) || (cnt < thr);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_off_when_zero;
    (ce && duty == 8'h00 && !force_full) |=> !drive;
  endproperty
  a_off_when_zero: assert property (p_off_when_zero)
    else $error("fan drive active with zero duty");

  property p_forced_full;
    (ce && force_full) |=> drive;
  endproperty
  a_forced_full: assert property (p_forced_full)
    else $error("forced full speed not applied");
endmodule

// File: hdl/fmc_pkg.sv
// Types shared by the fan monitor configuration and fail-safe block.
package fmc_pkg;
  typedef enum logic [3:0] {
    FMC_IDLE,
    FMC_ADDR,
    FMC_ACK_ADDR,
    FMC_CMD,
    FMC_ACK_CMD,
    FMC_WDATA,
    FMC_ACK_WDATA,
    FMC_RDATA,
    FMC_RACK,
    FMC_IGNORE
  } fmc_smb_state_type;
endpackage

// File: hdl/fmc_top.sv
// Fan monitor configuration, fail-safe supervisor and serial bus slave.
// Functional notes
// - drive-frequency bit 1 clear selects 22.5 kHz fan drive; bit resets to 0.
// - drive-frequency bit 1 selects low-rate drive programmable 10 Hz to 100 Hz.
// - monitoring enables itself once main supply and core voltage are good.
// - without core voltage, first completed addressed transaction enables monitoring.
// - fans are off after power-up until programmed.
// - with monitoring enabled, any temperature above thermal limit (default 100 C) forces full speed.
// - no addressing within 4.6 s after core voltage good forces full speed.
// - programming is accepted anytime, also after fail-safe, and is obeyed.
// - without core voltage the missing-host timer never starts.
// - range bit 1 selects signed -127..+127 temperature coding everywhere.
// - extended offset-64 range spans -64..191; range bit resets to 1.
// - config five bit 2 sets general pin direction, bit 3 polarity.
// - config four bits 1:0 choose fan4 speed, thermal pin, alert, or general pin.
// - status two bit 5 reports the shared pin status of the active role, held 0 in alert role.
// - programmable maximum duty caps the automatic loop drive.
// - temperature offset spans plus or minus 64 C in half degrees.
// - slave answers only at fixed address 0x2E.
// - config five lives at register address 0x7C.
// - in alert role the pin is an open-drain out-of-limit output.
// - in thermal pin role it is monitored and driven on over-temperature.
`timescale 1ns/10ps
`include "fmc_cfg.svh"
module fmc_top #(
  parameter int HF_PERIOD_CYCLES    = `FMC_CLOCK_HZ / `FMC_HF_FREQ_HZ,
  parameter int LF_BASE_CYCLES      = `FMC_CLOCK_HZ / `FMC_LF_MAX_FREQ_HZ,
  parameter int HOST_TIMEOUT_CYCLES = `FMC_HOST_TIMEOUT_MS * (`FMC_CLOCK_HZ / `FMC_MS_PER_S)
) (
  input  wire logic       CLOCK,
  input  wire logic       SRST,
  input  wire logic       CE,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       MAIN_SUPPLY_GOOD,
  input  wire logic       CORE_VOLTAGE_INPUT_GOOD,
  input  wire logic [7:0] TEMP_LOCAL,
  input  wire logic [7:0] TEMP_REMOTE1,
  input  wire logic [7:0] TEMP_REMOTE2,
  input  wire logic [7:0] AUTO_DUTY_1,
  input  wire logic [7:0] AUTO_DUTY_2,
  input  wire logic [7:0] AUTO_DUTY_3,
  input  wire logic       FAN4_SPEED_ALARM,
  input  wire logic       ALERT_REQUEST,
  input  wire logic       MF_PIN_IN,
  output logic            MF_PIN_OUT,
  output logic            MF_PIN_OE,
  output logic [2:0]      FAN_DRIVE,
  output logic            MONITOR_ENABLE,
  output logic            TEMP_RANGE_SIGNED,
  output logic            FAIL_SAFE_ACTIVE
);
  localparam logic [23:0] HF_PERIOD    = 24'(HF_PERIOD_CYCLES);
  localparam logic [23:0] LF_BASE      = 24'(LF_BASE_CYCLES);
  localparam logic [31:0] TIMEOUT_LAST = 32'(HOST_TIMEOUT_CYCLES - 1);

  fmc_pkg::fmc_smb_state_type state;
  logic        scl_q;
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start;
  logic        stop;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  rd_shift;
  logic [7:0]  pointer;
  logic        rw;
  logic        wr_stb;
  logic [7:0]  wr_data;
  logic        rd_stb;
  logic        addr_hit;
  logic        txn_addressed;
  logic        txn_done;
  logic [7:0]  read_data;
  logic [7:0]  cfg5;
  logic [7:0]  cfg4;
  logic        gpio_drive;
  logic [7:0]  duty [0:2];
  logic [7:0]  max_duty;
  logic [2:0]  auto_en;
  logic [3:0]  lf_div;
  logic [7:0]  thermal_limit_pin_limit;
  logic [7:0]  temp_offset;
  logic        core_started;
  logic        host_seen;
  logic        host_lost;
  logic        timer_run;
  logic [31:0] timer;
  logic        thermal_fs;
  logic        over_any;
  logic        thermal_limit_pin_seen;
  logic        pin_status;
  logic        gpio_active;
  logic [1:0]  role;
  logic [27:0] lf_prod;
  logic [23:0] period;
  logic [7:0]  auto_duty [0:2];
  logic [7:0]  temp_in [0:2];
  logic [7:0]  duty_eff [0:2];
  logic [7:0]  status2;

  assign SDA_OUT    = 1'b0;
  assign MF_PIN_OUT = 1'b0;
  assign scl_rise   = SCL & ~scl_q;
  assign scl_fall   = ~SCL & scl_q;
  assign start      = scl_q & SCL & sda_q & ~SDA_IN;
  assign stop       = scl_q & SCL & ~sda_q & SDA_IN;
  assign role       = cfg4[1:0];
  assign TEMP_RANGE_SIGNED = cfg5[`FMC_CFG5_RANGE];
  assign FAIL_SAFE_ACTIVE  = thermal_fs | host_lost;
  assign auto_duty[0] = AUTO_DUTY_1;
  assign auto_duty[1] = AUTO_DUTY_2;
  assign auto_duty[2] = AUTO_DUTY_3;
  assign temp_in[0]   = TEMP_LOCAL;
  assign temp_in[1]   = TEMP_REMOTE1;
  assign temp_in[2]   = TEMP_REMOTE2;

  // Converts a coded temperature to signed half degrees in the selected range.
  function automatic logic signed [10:0] to_half(input logic [7:0] t, input logic signed_rng);
    logic signed [10:0] d;
    d = signed_rng ? $signed({{3{t[7]}}, t}) : $signed({3'b000, t}) - `FMC_EXT_OFFSET;
    to_half = {d[9:0], 1'b0};
  endfunction

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (CE) begin
      scl_q <= SCL;
      sda_q <= SDA_IN;
    end
  end

  // Bits are sampled on the clock rise and the data line changes after the fall.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state         <= fmc_pkg::FMC_IDLE;
      bit_cnt       <= '0;
      shift         <= '0;
      rd_shift      <= '0;
      pointer       <= '0;
      rw            <= 1'b0;
      SDA_OE        <= 1'b0;
      wr_stb        <= 1'b0;
      wr_data       <= '0;
      rd_stb        <= 1'b0;
      addr_hit      <= 1'b0;
      txn_addressed <= 1'b0;
      txn_done      <= 1'b0;
    end else if (CE) begin
      wr_stb   <= 1'b0;
      rd_stb   <= 1'b0;
      addr_hit <= 1'b0;
      txn_done <= 1'b0;
      if (start) begin
        state   <= fmc_pkg::FMC_ADDR;
        bit_cnt <= '0;
        SDA_OE  <= 1'b0;
      end else if (stop) begin
        state         <= fmc_pkg::FMC_IDLE;
        SDA_OE        <= 1'b0;
        txn_done      <= txn_addressed;
        txn_addressed <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          fmc_pkg::FMC_ADDR, fmc_pkg::FMC_CMD, fmc_pkg::FMC_WDATA: begin
            shift   <= {shift[6:0], SDA_IN};
            bit_cnt <= bit_cnt + 4'h1;
          end
          fmc_pkg::FMC_RDATA: bit_cnt <= bit_cnt + 4'h1;
          fmc_pkg::FMC_RACK: begin
            if (SDA_IN) begin
              state <= fmc_pkg::FMC_IGNORE;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          fmc_pkg::FMC_ADDR: begin
            if (bit_cnt == `FMC_BITS_PER_BYTE) begin
              if (shift[7:1] == `FMC_SLAVE_ADDR) begin
                SDA_OE        <= 1'b1;
                rw            <= shift[0];
                addr_hit      <= 1'b1;
                txn_addressed <= 1'b1;
                state         <= fmc_pkg::FMC_ACK_ADDR;
              end else begin
                state <= fmc_pkg::FMC_IGNORE;
              end
            end
          end
          fmc_pkg::FMC_ACK_ADDR, fmc_pkg::FMC_RACK: begin
            bit_cnt <= '0;
            if (rw) begin
              rd_shift <= read_data;
              SDA_OE   <= ~read_data[7];
              rd_stb   <= 1'b1;
              state    <= fmc_pkg::FMC_RDATA;
            end else begin
              SDA_OE <= 1'b0;
              state  <= fmc_pkg::FMC_CMD;
            end
          end
          fmc_pkg::FMC_CMD: begin
            if (bit_cnt == `FMC_BITS_PER_BYTE) begin
              pointer <= shift;
              SDA_OE  <= 1'b1;
              state   <= fmc_pkg::FMC_ACK_CMD;
            end
          end
          fmc_pkg::FMC_WDATA: begin
            if (bit_cnt == `FMC_BITS_PER_BYTE) begin
              wr_stb  <= 1'b1;
              wr_data <= shift;
              SDA_OE  <= 1'b1;
              state   <= fmc_pkg::FMC_ACK_WDATA;
            end
          end
          fmc_pkg::FMC_ACK_CMD, fmc_pkg::FMC_ACK_WDATA: begin
            bit_cnt <= '0;
            SDA_OE  <= 1'b0;
            state   <= fmc_pkg::FMC_WDATA;
          end
          fmc_pkg::FMC_RDATA: begin
            if (bit_cnt == `FMC_BITS_PER_BYTE) begin
              SDA_OE <= 1'b0;
              state  <= fmc_pkg::FMC_RACK;
            end else begin
              rd_shift <= {rd_shift[6:0], 1'b0};
              SDA_OE   <= ~rd_shift[6];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Writes land whenever they arrive, fail-safe or not.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cfg5        <= `FMC_CFG5_RESET;
      cfg4        <= `FMC_CFG4_RESET;
      gpio_drive  <= 1'b0;
      duty[0]     <= `FMC_DUTY_RESET;
      duty[1]     <= `FMC_DUTY_RESET;
      duty[2]     <= `FMC_DUTY_RESET;
      max_duty    <= `FMC_MAX_DUTY_RESET;
      auto_en     <= '0;
      lf_div      <= `FMC_LF_DIV_RESET;
      thermal_limit_pin_limit <= `FMC_THERMAL_LIMIT_PIN_LIMIT_RESET;
      temp_offset <= `FMC_OFFSET_RESET;
    end else if (CE && wr_stb) begin
      case (pointer)
        `FMC_REG_CFG5:        cfg5 <= wr_data;
        `FMC_REG_CFG4:        cfg4 <= wr_data;
        `FMC_REG_GPIO_DRIVE:  gpio_drive <= wr_data[0];
        `FMC_REG_DUTY1:       duty[0] <= wr_data;
        `FMC_REG_DUTY2:       duty[1] <= wr_data;
        `FMC_REG_DUTY3:       duty[2] <= wr_data;
        `FMC_REG_MAX_DUTY:    max_duty <= wr_data;
        `FMC_REG_AUTO_EN:     auto_en <= wr_data[2:0];
        `FMC_REG_LF_DIV: begin
          if (wr_data[3:0] < `FMC_LF_DIV_MIN || wr_data[7:4] != 4'h0) begin
            lf_div <= (wr_data[7:4] != 4'h0) ? `FMC_LF_DIV_MAX : `FMC_LF_DIV_MIN;
          end else if (wr_data[3:0] > `FMC_LF_DIV_MAX) begin
            lf_div <= `FMC_LF_DIV_MAX;
          end else begin
            lf_div <= wr_data[3:0];
          end
        end
        `FMC_REG_THERMAL_LIMIT_PIN_LIMIT: thermal_limit_pin_limit <= wr_data;
        `FMC_REG_TEMP_OFFSET: temp_offset <= wr_data;
        default: ;
      endcase
    end
  end

  assign status2 = {2'h0, pin_status, 5'h00};

  always_comb begin
    case (pointer)
      `FMC_REG_TEMP_LOCAL:   read_data = TEMP_LOCAL;
      `FMC_REG_TEMP_REMOTE1: read_data = TEMP_REMOTE1;
      `FMC_REG_TEMP_REMOTE2: read_data = TEMP_REMOTE2;
      `FMC_REG_DUTY1:        read_data = duty[0];
      `FMC_REG_DUTY2:        read_data = duty[1];
      `FMC_REG_DUTY3:        read_data = duty[2];
      `FMC_REG_MAX_DUTY:     read_data = max_duty;
      `FMC_REG_STATUS2:      read_data = status2;
      `FMC_REG_AUTO_EN:      read_data = {5'h00, auto_en};
      `FMC_REG_LF_DIV:       read_data = {4'h0, lf_div};
      `FMC_REG_THERMAL_LIMIT_PIN_LIMIT:  read_data = thermal_limit_pin_limit;
      `FMC_REG_TEMP_OFFSET:  read_data = temp_offset;
      `FMC_REG_CFG5:         read_data = cfg5;
      `FMC_REG_CFG4:         read_data = cfg4;
      `FMC_REG_GPIO_DRIVE:   read_data = {7'h00, gpio_drive};
      `FMC_REG_SUPERVISOR:   read_data = {5'h00, host_lost, thermal_fs, MONITOR_ENABLE};
      default:               read_data = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      MONITOR_ENABLE <= 1'b0;
    end else if (CE) begin
      if ((MAIN_SUPPLY_GOOD && CORE_VOLTAGE_INPUT_GOOD) || txn_done) begin
        MONITOR_ENABLE <= 1'b1;
      end
    end
  end

  // The timer never restarts: a late host is still honoured and clears the forcing.
  assign timer_run = core_started && !host_seen && !host_lost;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      core_started <= 1'b0;
      host_seen    <= 1'b0;
      host_lost    <= 1'b0;
      timer        <= '0;
    end else if (CE) begin
      if (CORE_VOLTAGE_INPUT_GOOD) begin
        core_started <= 1'b1;
      end
      if (addr_hit) begin
        host_seen <= 1'b1;
      end
      if (timer_run) begin
        timer <= timer + 32'h00000001;
      end
      if (timer_run && timer == TIMEOUT_LAST) begin
        host_lost <= 1'b1;
      end else if (addr_hit) begin
        host_lost <= 1'b0;
      end
    end
  end

  always_comb begin
    over_any = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (to_half(temp_in[i], cfg5[`FMC_CFG5_RANGE]) + $signed({{3{temp_offset[7]}}, temp_offset})
          > to_half(thermal_limit_pin_limit, cfg5[`FMC_CFG5_RANGE])) begin
        over_any = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      thermal_fs <= 1'b0;
    end else if (CE) begin
      thermal_fs <= MONITOR_ENABLE && over_any;
    end
  end

  assign gpio_active = cfg5[`FMC_CFG5_GPIO_POL] ? MF_PIN_IN : ~MF_PIN_IN;

  always_comb begin
    case (role)
      `FMC_ROLE_FAN4:        pin_status = FAN4_SPEED_ALARM;
      `FMC_ROLE_THERMAL_PIN: pin_status = thermal_limit_pin_seen;
      `FMC_ROLE_GPIO:        pin_status = gpio_active;
      default:               pin_status = 1'b0;
    endcase
  end

  // A new assertion in the cycle of the clearing read survives the read.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      thermal_limit_pin_seen <= 1'b0;
    end else if (CE) begin
      if (role == `FMC_ROLE_THERMAL_PIN && !MF_PIN_IN) begin
        thermal_limit_pin_seen <= 1'b1;
      end else if (rd_stb && pointer == `FMC_REG_STATUS2) begin
        thermal_limit_pin_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      MF_PIN_OE <= 1'b0;
    end else if (CE) begin
      case (role)
        `FMC_ROLE_ALERT:        MF_PIN_OE <= ALERT_REQUEST;
        `FMC_ROLE_THERMAL_PIN:  MF_PIN_OE <= thermal_fs;
        `FMC_ROLE_GPIO:         MF_PIN_OE <= cfg5[`FMC_CFG5_GPIO_DIR]
                                             & (gpio_drive ^ cfg5[`FMC_CFG5_GPIO_POL]);
        default:                MF_PIN_OE <= 1'b0;
      endcase
    end
  end

  assign lf_prod = LF_BASE * lf_div;
  assign period  = cfg5[`FMC_CFG5_LOWFREQ] ? lf_prod[23:0] : HF_PERIOD;

  for (genvar g = 0; g < 3; g++) begin : g_fan
    assign duty_eff[g] = !auto_en[g] ? duty[g]
                       : (auto_duty[g] > max_duty) ? max_duty : auto_duty[g];
    fmc_drive u_drive (
      .clk        (CLOCK),
      .srst       (SRST),
      .ce         (CE),
      .period     (period),
      .duty       (duty_eff[g]),
      .force_full (FAIL_SAFE_ACTIVE),
      .drive      (FAN_DRIVE[g])
    );
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  property p_addr_ack;
    (CE && scl_fall && !start && !stop && state == fmc_pkg::FMC_ADDR
     && bit_cnt == `FMC_BITS_PER_BYTE && shift[7:1] == `FMC_SLAVE_ADDR) |=> SDA_OE && addr_hit;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_timeout;
    (CE && timer_run && timer == TIMEOUT_LAST) |=> host_lost;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("host timeout did not force full speed");

  property p_no_core_no_timeout;
    !core_started |-> !host_lost && timer == 32'h00000000;
  endproperty
  a_no_core_no_timeout: assert property (p_no_core_no_timeout)
    else $error("host timer ran without core voltage");

  property p_timer_frozen;
    host_seen |=> $stable(timer);
  endproperty
  a_timer_frozen: assert property (p_timer_frozen)
    else $error("host timer moved after addressing");

  property p_failsafe_all;
    (CE && FAIL_SAFE_ACTIVE) |=> FAN_DRIVE == 3'h7;
  endproperty
  a_failsafe_all: assert property (p_failsafe_all)
    else $error("fail-safe did not drive every fan");

  property p_power_monitor;
    (CE && MAIN_SUPPLY_GOOD && CORE_VOLTAGE_INPUT_GOOD) |=> MONITOR_ENABLE;
  endproperty
  a_power_monitor: assert property (p_power_monitor)
    else $error("monitoring not enabled by power");

  property p_txn_monitor;
    (CE && txn_done) |=> MONITOR_ENABLE;
  endproperty
  a_txn_monitor: assert property (p_txn_monitor)
    else $error("monitoring not enabled by transaction");

  property p_over_temp;
    (CE && MONITOR_ENABLE && over_any) ##1 CE |=> FAN_DRIVE == 3'h7;
  endproperty
  a_over_temp: assert property (p_over_temp)
    else $error("over-temperature did not force full speed");

  property p_alert_pin;
    (CE && role == `FMC_ROLE_ALERT) |=> MF_PIN_OE == $past(ALERT_REQUEST);
  endproperty
  a_alert_pin: assert property (p_alert_pin)
    else $error("alert pin does not follow request");

  property p_fan4_release;
    (CE && role == `FMC_ROLE_FAN4) |=> !MF_PIN_OE;
  endproperty
  a_fan4_release: assert property (p_fan4_release)
    else $error("pin driven in fan4 speed role");
endmodule
